// File: design/nv_map.svh
// address map, field positions, reset values and timing counts of the eeprom controller
`ifndef NV_MAP_SVH
`define NV_MAP_SVH

// data-space addresses seen by the core
`define NV_WIN_LAST 8'h3F
`define NV_BANK_ADDR 8'hE8
`define NV_CTRL_ADDR 8'hEA

// control register fields
`define NV_EN_BIT 0
`define NV_BUSY_BIT 1
`define NV_PE_BIT 2
`define NV_PS_BIT 3
`define NV_TEST_LO 4
`define NV_TEST_HI 5
`define NV_SB_BIT 6
`define NV_CTRL_RESET 8'h00
`define NV_BANK_RESET 8'h00
`define NV_ABORT_DATA 8'h00

// array geometry
`define NV_BYTES 384
`define NV_ROW_BYTES 8

// programming time
`define NV_CLK_MHZ 200
`define NV_PROG_TIME_US 5000
`define NV_PROG_MAX_US 10000
`define NV_PROG_CYCLES (`NV_PROG_TIME_US * `NV_CLK_MHZ)

// host register offsets on apb
`define HOST_CMD_OFF 12'h000
`define HOST_STAT_OFF 12'h004
`define HOST_WR_BIT 16
`define HOST_PEND_BIT 8

`endif

// File: design/nv_pkg.sv
// types shared by the eeprom controller and its host
package nv_pkg;
  `include "nv_map.svh"

  typedef struct packed {
    logic [7:0] bank;
    logic standby;
    logic ps;
    logic pe;
    logic en;
    logic busy;
    logic row_locked;
    logic [5:0] row;
    logic [7:0] mask;
    logic [63:0] latch;
    logic [7:0] rdata;
    logic rvalid;
  } nvc_state_t;

  typedef struct packed {
    logic run;
    logic [19:0] cnt;
    logic done;
  } timer_state_t;

  typedef enum logic [2:0] {
    H_IDLE,
    H_POLL,
    H_ACC_RD,
    H_DONE
  } host_fsm_t;

  typedef struct packed {
    host_fsm_t fsm;
    logic [7:0] addr;
    logic [7:0] data;
    logic is_wr;
    logic [7:0] tgt_addr;
    logic rd;
    logic wr;
    logic [7:0] rdata;
  } host_state_t;
endpackage

// File: design/nv_bus_if.sv
// internal data bus between the core side and the eeprom controller
`timescale 1ns/1ps
`default_nettype none
interface nv_bus_if (
  input wire logic pclk
);
  logic [7:0] addr;
  logic [7:0] wdata;
  logic wr;
  logic rd;
  logic [7:0] rdata;
  logic rvalid;

  modport core (output addr, output wdata, output wr, output rd, input rdata, input rvalid);
  modport nvc (input addr, input wdata, input wr, input rd, output rdata, output rvalid);
endinterface
`default_nettype wire

// File: design/nv_prog_timer.sv
// programming interval timer: one pulse when the interval ends
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
module nv_prog_timer import nv_pkg::*; #(
  parameter int unsigned CYCLES = `NV_PROG_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic start,
  output logic done
);
  timer_state_t t_q, t_d;

  always_comb begin
    t_d = t_q;
    t_d.done = 1'b0;
    if (start) begin
      t_d.run = 1'b1;
      t_d.cnt = 20'(CYCLES - 1);
    end else if (t_q.run) begin
      if (t_q.cnt == 20'h00000) begin
        t_d.run = 1'b0;
        t_d.done = 1'b1;
      end else begin
        t_d.cnt = t_q.cnt - 20'h00001;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_q <= '0;
    end else begin
      t_q <= t_d;
    end
  end

  assign done = t_q.done;
endmodule
`default_nettype wire

// File: design/nv_ctrl_dev.sv
// paged data eeprom with byte and row write modes, device end of the core bus
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
module nv_ctrl_dev import nv_pkg::*; #(
  parameter int unsigned PROG_CYCLES = `NV_PROG_CYCLES
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core bus
  nv_bus_if.nvc bus,
  // status towards the rest of the chip
  output logic nv_busy,
  output logic nv_standby
);
  nvc_state_t s_q, s_d;
  logic [7:0] mem [`NV_BYTES];
  logic prog_start;
  logic prog_done;
  logic in_win;
  logic page_ok;
  logic [2:0] page;
  logic [8:0] lin;
  logic [5:0] lane;
  logic ctrl_ps_ok;
  logic arr_ok;
  logic bank_wr;
  logic ctrl_wr;
  logic ctrl_rd;
  logic win_wr;
  logic win_rd;
  logic row_hit;
  logic pe_rise;
  logic pe_drop;
  logic [7:0] lane_bit;
  logic [7:0] lane_we;

  // bank decode: bits 7,1,0 belong to the eeprom, all others must be clear
  always_comb begin
    page_ok = (s_q.bank[1:0] != 2'b00) && (s_q.bank[6:2] == 5'b00000);
    page = (s_q.bank[7] ? 3'd3 : 3'd0) + {1'b0, s_q.bank[1:0]} - 3'd1;
  end

  assign in_win = (bus.addr <= `NV_WIN_LAST);
  assign lin = {page, bus.addr[5:0]};
  assign lane = {lin[2:0], 3'b000};
  assign ctrl_ps_ok = bus.wdata[`NV_PS_BIT] && bus.wdata[`NV_EN_BIT]
    && bus.wdata[`NV_PE_BIT] && s_q.pe;

  // the array answers only with a valid page, out of standby and while idle
  assign arr_ok = in_win && page_ok && !s_q.busy && !s_q.standby;
  assign bank_wr = bus.wr && (bus.addr == `NV_BANK_ADDR);
  // busy blocks every write to the register; a read shows only the busy flag, busy or not
  assign ctrl_wr = bus.wr && (bus.addr == `NV_CTRL_ADDR) && !s_q.busy;
  assign ctrl_rd = bus.rd && (bus.addr == `NV_CTRL_ADDR);
  assign win_wr = bus.wr && arr_ok && s_q.en;
  assign win_rd = bus.rd && arr_ok;
  // once locked, only the latched row may fill the latches
  assign row_hit = !s_q.row_locked || (lin[8:3] == s_q.row);
  assign pe_rise = bus.wdata[`NV_PE_BIT] && !s_q.pe;
  assign pe_drop = !bus.wdata[`NV_PE_BIT];
  assign lane_bit = 8'h01 << lin[2:0];

  // one commit enable per row byte; unwritten bytes keep their old value
  for (genvar i = 0; i < `NV_ROW_BYTES; i++) begin : g_lane
    assign lane_we[i] = prog_done && s_q.mask[i];
  end

  nv_prog_timer #(
    .CYCLES(PROG_CYCLES)
  ) u_timer (
    .pclk(pclk),
    .presetn(presetn),
    .start(prog_start),
    .done(prog_done)
  );

  always_comb begin
    s_d = s_q;
    s_d.rvalid = 1'b0;
    prog_start = 1'b0;

    // end of an interval frees the array and drops the row mode
    if (prog_done) begin
      s_d.busy = 1'b0;
      s_d.ps = 1'b0;
      s_d.pe = 1'b0;
      s_d.mask = 8'h00;
      s_d.row_locked = 1'b0;
    end

    // the bank register is write-only and always writable
    if (bank_wr) begin
      s_d.bank = bus.wdata;
    end

    if (ctrl_wr) begin
      s_d.en = bus.wdata[`NV_EN_BIT];
      s_d.standby = bus.wdata[`NV_SB_BIT];
      s_d.pe = bus.wdata[`NV_PE_BIT];
      if (pe_rise) begin
        s_d.mask = 8'h00;
        s_d.latch = '0;
        s_d.row_locked = 1'b0;
      end else if (pe_drop) begin
        // dropping enable before start throws the latches away
        s_d.mask = 8'h00;
        s_d.row_locked = 1'b0;
      end
      if (ctrl_ps_ok) begin
        s_d.ps = 1'b1;
        s_d.busy = 1'b1;
        prog_start = 1'b1;
      end
    end

    if (win_wr) begin
      if (s_q.pe) begin
        // row mode: fill volatile latches, a foreign row is dropped
        if (!s_q.ps && row_hit) begin
          s_d.row_locked = 1'b1;
          s_d.row = lin[8:3];
          s_d.latch[lane +: 8] = bus.wdata;
          s_d.mask = s_q.mask | lane_bit;
        end
      end else begin
        // byte mode reuses the latches with a single lane
        s_d.row = lin[8:3];
        s_d.latch[lane +: 8] = bus.wdata;
        s_d.mask = lane_bit;
        s_d.busy = 1'b1;
        prog_start = 1'b1;
      end
    end

    // every read is answered one cycle later; refused ones return the abort value
    if (bus.rd) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = `NV_ABORT_DATA;
      if (ctrl_rd) begin
        s_d.rdata[`NV_BUSY_BIT] = s_q.busy;
      end else if (win_rd) begin
        s_d.rdata = mem[lin];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.bank <= `NV_BANK_RESET;
      {s_q.standby, s_q.ps, s_q.pe, s_q.en} <= 4'h0;
    end else begin
      s_q <= s_d;
    end
  end

  // the array has no reset; only lanes written since enable are programmed
  always_ff @(posedge pclk) begin
    if (prog_done) begin
      for (int i = 0; i < `NV_ROW_BYTES; i++) begin
        if (lane_we[i]) begin
          mem[{s_q.row, 3'(i)}] <= s_q.latch[i*8 +: 8];
        end
      end
    end
  end

  assign bus.rdata = s_q.rdata;
  assign bus.rvalid = s_q.rvalid;
  assign nv_busy = s_q.busy;
  assign nv_standby = s_q.standby;
endmodule
`default_nettype wire

// File: design/nv_host.sv
// apb-driven bus master that performs core accesses towards the eeprom controller
`timescale 1ns/1ps
`default_nettype none
`include "nv_map.svh"
module nv_host import nv_pkg::*; (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core bus
  nv_bus_if.core bus
);
  host_state_t h_q, h_d;
  logic apb_acc;
  logic hit_cmd;
  logic hit_stat;
  logic pending;

  assign apb_acc = psel && penable;
  assign hit_cmd = (paddr == `HOST_CMD_OFF);
  assign hit_stat = (paddr == `HOST_STAT_OFF);
  assign pending = (h_q.fsm != H_IDLE);
  assign pready = 1'b1;
  assign pslverr = apb_acc && !hit_cmd && !hit_stat;

  always_comb begin
    prdata = 32'h00000000;
    if (hit_cmd) begin
      prdata = {15'h0000, h_q.is_wr, h_q.data, h_q.tgt_addr};
    end else if (hit_stat) begin
      prdata = {23'h000000, pending, h_q.rdata};
    end
  end

  always_comb begin
    h_d = h_q;
    h_d.rd = 1'b0;
    h_d.wr = 1'b0;
    unique case (h_q.fsm)
      H_IDLE: begin
        // a command written while one is pending is dropped
        if (apb_acc && pwrite && hit_cmd) begin
          h_d.tgt_addr = pwdata[7:0];
          h_d.data = pwdata[15:8];
          h_d.is_wr = pwdata[`HOST_WR_BIT];
          // whole-byte writes only; test bits always go out as zero
          if (pwdata[7:0] == `NV_CTRL_ADDR) begin
            h_d.data[`NV_TEST_HI:`NV_TEST_LO] = 2'b00;
          end
          // check busy first, also before control writes
          h_d.addr = `NV_CTRL_ADDR;
          h_d.rd = 1'b1;
          h_d.fsm = H_POLL;
        end
      end
      H_POLL: begin
        if (bus.rvalid) begin
          if (bus.rdata[`NV_BUSY_BIT]) begin
            h_d.rd = 1'b1;
          end else begin
            h_d.addr = h_q.tgt_addr;
            h_d.wr = h_q.is_wr;
            h_d.rd = !h_q.is_wr;
            h_d.fsm = h_q.is_wr ? H_DONE : H_ACC_RD;
          end
        end
      end
      H_ACC_RD: begin
        if (bus.rvalid) begin
          h_d.rdata = bus.rdata;
          h_d.fsm = H_IDLE;
        end
      end
      H_DONE: begin
        h_d.fsm = H_IDLE;
      end
      // unused codes of the 3-bit state fall back to idle
      default: begin
        h_d.fsm = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      h_q <= '0;
      h_q.fsm <= H_IDLE;
    end else begin
      h_q <= h_d;
    end
  end

  assign bus.addr = h_q.addr;
  assign bus.wdata = h_q.data;
  assign bus.wr = h_q.wr;
  assign bus.rd = h_q.rd;
endmodule
`default_nettype wire

// File: test/nv_bus_properties.sv
// concurrent checks on the core bus between host and eeprom controller
`timescale 1ns/1ps
`default_nettype none
module nv_bus_properties #(
  parameter int unsigned PROG = 20
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // core bus
  input wire logic [7:0] addr,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic rvalid,
  // status
  input wire logic nv_busy
);
  int unsigned cnt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 0;
    else cnt_q <= nv_busy ? cnt_q + 1 : 0;
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_win_write;
    wr && addr <= 8'h3F;
  endsequence
  sequence s_hold;
    nv_busy [*8];
  endsequence
  a_read_answer: assert property (rd |=> rvalid)
    else $error("read not answered");
  a_answer_cause: assert property (rvalid |-> $past(rd))
    else $error("answer without read");
  a_rdata_hold: assert property (!rvalid |-> $stable(rdata))
    else $error("read data moved");
  a_one_request: assert property (!(wr && rd))
    else $error("read and write together");
  a_polled_write: assert property (s_win_write |-> $past(rvalid) && !$past(rdata[1]))
    else $error("write without busy poll");
  a_busy_cause: assert property ($rose(nv_busy) |-> $past(wr))
    else $error("busy without write");
  a_busy_hold: assert property ($rose(nv_busy) |-> s_hold)
    else $error("busy too short");
  a_busy_length: assert property ($fell(nv_busy) |-> cnt_q == PROG + 1)
    else $error("busy length wrong");
  a_bank_wo: assert property (rd && addr == 8'hE8 |=> rdata == 8'h00)
    else $error("bank select readable");
endmodule
`default_nettype wire

// File: test/tb.sv
// testbench: apb orders through the host into the eeprom controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; $display("wrong value t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import nv_pkg::*;
  localparam int unsigned PROG = 20;
  logic pclk = 0;
  logic presetn = 0;
  logic [11:0] paddr = '0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, nv_busy, nv_standby;
  logic chk = 0;
  logic [32:0] expq[$];
  logic [32:0] exp_v;
  logic [7:0] mem [384];
  logic [7:0] bk [6] = '{8'h01, 8'h02, 8'h03, 8'h81, 8'h82, 8'h83};
  logic [7:0] ra [3] = '{8'h18, 8'h1A, 8'h1B};
  logic [15:0] lfsr = 16'h9619;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  nv_bus_if u_bus (.pclk(pclk));
  nv_host u_nv_host (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bus(u_bus));
  nv_ctrl_dev #(.PROG_CYCLES(PROG)) u_nv_ctrl_dev (.pclk(pclk), .presetn(presetn),
    .bus(u_bus), .nv_busy(nv_busy), .nv_standby(nv_standby));
  nv_bus_properties #(.PROG(PROG)) u_nv_bus_properties (.pclk(pclk), .presetn(presetn),
    .addr(u_bus.addr), .wr(u_bus.wr), .rd(u_bus.rd), .rdata(u_bus.rdata),
    .rvalid(u_bus.rvalid), .nv_busy(nv_busy));
  initial begin
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    return lfsr[7:0];
  endfunction
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // only reads flagged by the driver are compared; busy polls pass unchecked
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && chk) begin
      exp_v = expq.pop_front();
      `CHK({pslverr, prdata}, exp_v)
    end
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic c, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    chk <= c;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 0;
    penable <= 0;
    chk <= 0;
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
    logic [31:0] q;
    int n;
    apb(1, 12'h000, {15'h0000, w, d, a}, 0, q);
    n = 0;
    do begin
      apb(0, 12'h004, 32'h0, 0, q);
      n++;
    end while (q[8] !== 1'b0 && n < 200);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] q;
    op(0, a, 8'h00);
    expq.push_back({9'h000, 16'h0000, e});
    apb(0, 12'h004, 32'h0, 1, q);
  endtask
  initial begin
    logic [31:0] q;
    int p;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    expq.push_back(33'h0);
    apb(0, 12'h004, 32'h0, 1, q);
    expq.push_back({1'b1, 32'h0});
    apb(0, 12'h010, 32'h0, 1, q);
    rd_chk(8'hEA, 8'h00);
    rd_chk(8'hE8, 8'h00);
    op(1, 8'hEA, 8'h01);
    for (p = 0; p < 6; p++) begin
      mem[p * 64 + 63] = rnd();
      op(1, 8'hE8, bk[p]);
      op(1, 8'h3F, mem[p * 64 + 63]);
    end
    for (p = 0; p < 6; p++) begin
      op(1, 8'hE8, bk[p]);
      rd_chk(8'h3F, mem[p * 64 + 63]);
    end
    op(1, 8'hE8, 8'h04);
    rd_chk(8'h3F, 8'h00);
    op(1, 8'hE8, 8'h01);
    op(1, 8'hEA, 8'h00);
    op(1, 8'h3F, ~mem[63]);
    op(1, 8'hEA, 8'h01);
    rd_chk(8'h3F, mem[63]);
    mem[24] = rnd();
    op(1, 8'h18, mem[24]);
    mem[32] = rnd();
    op(1, 8'h20, mem[32]);
    op(1, 8'hEA, 8'h05); // row mode on; the next write only fills the latches
    op(1, 8'h18, ~mem[24]);
    op(1, 8'hEA, 8'h01);
    rd_chk(8'h18, mem[24]);
    op(1, 8'hEA, 8'h05);
    foreach (ra[i]) begin
      mem[ra[i]] = rnd();
      op(1, ra[i], mem[ra[i]]);
    end
    op(1, 8'h20, ~mem[32]);
    op(1, 8'hEA, 8'h0D);
    mem[25] = rnd();
    op(1, 8'h19, mem[25]);
    rd_chk(8'h19, mem[25]);
    foreach (ra[i]) rd_chk(ra[i], mem[ra[i]]);
    rd_chk(8'h20, mem[32]);
    op(1, 8'hEA, 8'h41);
    `CHK(nv_standby, 1'b1)
    rd_chk(8'h18, 8'h00);
    op(1, 8'hEA, 8'h01);
    `CHK(nv_standby, 1'b0)
    rd_chk(8'h18, mem[24]);
    stop_test();
  end
endmodule
`default_nettype wire
